//--- ncr_pkg.sv
// package for the nibble cpu core registers block
// assumes a single instruction-rate clock and decode outside this block
package ncr_pkg;
   localparam int NCR_NIB_W     = 4;    // nibble width
   localparam int NCR_PAIR_W    = 8;    // pair register width
   localparam int NCR_POFS_W    = 3;    // page-offset width
   localparam int NCR_INPAGE_W  = 7;    // in-page address width
   localparam int NCR_PAGE_W    = 5;    // page field width
   localparam int NCR_PC_W      = 12;   // full program counter width
   localparam int NCR_SIDX_W    = 3;    // stack index width
   localparam int NCR_DEPTH     = 8;    // return stack depth
   localparam int NCR_DPTR_W    = 8;    // data pointer width held by save stage
   localparam logic [3:0]  NCR_ACC_RST   = 4'h0;
   localparam logic [3:0]  NCR_AUX_RST   = 4'h0;
   localparam logic [11:0] NCR_PC_RST    = 12'h000;
   localparam logic [2:0]  NCR_SIDX_RST  = 3'h7;  // first push lands in entry 0
   localparam logic [2:0]  NCR_SIDX_TOP  = 3'h7;

   // operation codes issued by instruction decode, gray along common path
   typedef enum logic [4:0] {
      NCR_OP_NOP            = 5'h00,
      NCR_OP_ADD_IMM        = 5'h01,
      NCR_OP_ADD_MEMORY     = 5'h03,
      NCR_OP_ADD_WITH_CARRY = 5'h02,
      NCR_OP_AND_MEM        = 5'h06,
      NCR_OP_OR_MEM         = 5'h07,
      NCR_OP_CMP_MEM        = 5'h05,
      NCR_OP_BIT_SET        = 5'h04,
      NCR_OP_BIT_CLR        = 5'h0c,
      NCR_OP_BIT_TEST       = 5'h0d,
      NCR_OP_ROTATE_RIGHT   = 5'h0f,
      NCR_OP_SET_CARRY      = 5'h0e,
      NCR_OP_CLEAR_CARRY    = 5'h0a,
      NCR_OP_LOAD_ACC       = 5'h0b,
      NCR_OP_LOAD_AUX       = 5'h09,
      NCR_OP_SWAP_ACC_AUX   = 5'h08,
      NCR_OP_PAIR_FROM_AB   = 5'h18,
      NCR_OP_AB_FROM_PAIR   = 5'h19,
      NCR_OP_LOAD_POFS      = 5'h1b,
      NCR_OP_READ_STACK_PTR = 5'h1a,
      NCR_OP_BRANCH_LONG_ACC= 5'h1e,
      NCR_OP_CALL_LONG_ACC  = 5'h1f,
      NCR_OP_TABLE_LOOKUP   = 5'h1d,
      NCR_OP_CALL           = 5'h1c,
      NCR_OP_RETURN         = 5'h14,
      NCR_OP_INT_ENTRY      = 5'h15,
      NCR_OP_INT_RETURN     = 5'h17,
      NCR_OP_JUMP           = 5'h16,
      NCR_OP_SET_SKIP       = 5'h12
   } ncr_op_e;
endpackage

//--- ncr_core.sv
// nibble cpu datapath: alu, accumulator, carry, aux, pair, page offset,
// return stack with index, interrupt save stage, skip flag and program counter
// assumes decode presents one operation per instruction clock on i_op
// assumes memory reads happen outside and arrive on i_operand
// assumes a skipped slot still presents its op, which is then ignored unless it is interrupt entry or interrupt return
`timescale 1ns/1ns
`default_nettype none
module ncr_core
   import ncr_pkg::*;
(
   input  wire logic                          i_clock,
   input  wire logic                          i_rst,
   input  wire ncr_pkg::ncr_op_e              i_op,
   input  wire logic [ncr_pkg::NCR_NIB_W-1:0] i_operand,
   input  wire logic [1:0]                    i_bit_sel,
   input  wire logic [ncr_pkg::NCR_PC_W-1:0]  i_target,
   input  wire logic [ncr_pkg::NCR_DPTR_W-1:0] i_data_ptr,
   input  wire logic                          i_skip_cond,
   output logic [ncr_pkg::NCR_NIB_W-1:0]      o_acc,
   output logic [ncr_pkg::NCR_NIB_W-1:0]      o_aux,
   output logic [ncr_pkg::NCR_PAIR_W-1:0]     o_pair,
   output logic                               o_carry_bit,
   output logic                               o_skip,
   output logic [ncr_pkg::NCR_SIDX_W-1:0]     o_stack_index,
   output logic [ncr_pkg::NCR_PC_W-1:0]       o_pc,
   output logic [ncr_pkg::NCR_NIB_W-1:0]      o_mem_wdata,
   output logic                               o_mem_we,
   output logic [ncr_pkg::NCR_DPTR_W-1:0]     o_data_ptr_restore,
   output logic                               o_data_ptr_restore_valid
);
   import ncr_pkg::*;

   // architectural registers seen by software
   logic [NCR_NIB_W-1:0]    acc_reg;
   logic [NCR_NIB_W-1:0]    aux_reg;
   logic [NCR_PAIR_W-1:0]   pair_reg;
   logic [NCR_POFS_W-1:0]   page_offset_reg;
   logic                    carry_reg;
   logic                    skip_reg;
   logic [NCR_SIDX_W-1:0]   stack_index_reg;
   logic [NCR_PC_W-1:0]     pc_reg;

   // eight return slots, no reset: contents only mean something once pushed
   logic [NCR_PC_W-1:0]     return_stack_entry [NCR_DEPTH];

   // write-back and restore hand-offs to the memory and pointer owners
   logic [NCR_NIB_W-1:0]    mem_wdata_reg;
   logic                    mem_we_reg;
   logic [NCR_DPTR_W-1:0]   dptr_restore_reg;
   logic                    dptr_restore_valid_reg;

   // interrupt save stage fields
   logic [NCR_DPTR_W-1:0]   save_dptr_reg;
   logic                    save_carry_reg;
   logic                    save_skip_reg;
   logic [NCR_NIB_W-1:0]    save_acc_reg;
   logic [NCR_NIB_W-1:0]    save_aux_reg;

   // combinational helpers shared by several processes
   logic [NCR_NIB_W:0]      sum_next;
   logic [NCR_NIB_W-1:0]    bit_mask;
   logic [NCR_PC_W-1:0]     pc_seq;
   logic [NCR_PC_W-1:0]     in_page_target;
   logic [NCR_SIDX_W-1:0]   push_index;
   logic                    is_push;
   logic                    executes;

   // pc advance: in-page address wraps from 127 into next page
   // a plain binary add: the carry out of bit 6 moves into the page field
   // kept as a function so the skip path and the default path agree
   function automatic logic [NCR_PC_W-1:0] ncr_pc_inc(input logic [NCR_PC_W-1:0] pc);
      logic [NCR_PC_W-1:0] r;
      r = pc + 12'h001;
      return r;
   endfunction

   // in-page jump target built from page offset and accumulator
   // the page field is kept, so these jumps never leave the current page
   function automatic logic [NCR_PC_W-1:0] ncr_in_page(input logic [NCR_PC_W-1:0] pc,
                                                        input logic [NCR_POFS_W-1:0] ofs,
                                                        input logic [NCR_NIB_W-1:0] a);
      ncr_in_page = {pc[NCR_PC_W-1:NCR_INPAGE_W], ofs, a};
   endfunction

   // a skipped slot executes nothing; interrupt entry is never skipped
   // interrupt return always acts, so a restored skip cannot cancel it
   assign executes   = !skip_reg || (i_op == NCR_OP_INT_ENTRY)
                       || (i_op == NCR_OP_INT_RETURN);
   // shared nibble adder: carry-in only for add with carry
   assign sum_next   = {1'b0, acc_reg} + {1'b0, i_operand}
                       + {4'h0, (i_op == NCR_OP_ADD_WITH_CARRY) && carry_reg};
   // one-hot mask for bit set, clear and test
   assign bit_mask   = 4'h1 << i_bit_sel;
   // sequential pc and the target of accumulator-relative jumps
   assign pc_seq     = ncr_pc_inc(pc_reg);
   assign in_page_target = ncr_in_page(pc_reg, page_offset_reg, acc_reg);
   // a push lands one above the index; three bits wrap from 7 to 0
   assign push_index = stack_index_reg + 3'h1;
   // every kind of push shares one stack write and one index step
   assign is_push    = executes && (i_op == NCR_OP_CALL || i_op == NCR_OP_CALL_LONG_ACC
                       || i_op == NCR_OP_TABLE_LOOKUP || i_op == NCR_OP_INT_ENTRY);

   // accumulator: operand and result holder
   // compare and bit test leave it alone, their result is the skip flag
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         acc_reg <= NCR_ACC_RST;
      end else if (i_op == NCR_OP_INT_RETURN) begin
         acc_reg <= save_acc_reg;
      end else if (executes) begin
         case (i_op)
            NCR_OP_ADD_IMM, NCR_OP_ADD_MEMORY, NCR_OP_ADD_WITH_CARRY: begin
               acc_reg <= sum_next[NCR_NIB_W-1:0];
            end
            NCR_OP_AND_MEM:       acc_reg <= acc_reg & i_operand;
            NCR_OP_OR_MEM:        acc_reg <= acc_reg | i_operand;
            NCR_OP_ROTATE_RIGHT:  acc_reg <= {carry_reg, acc_reg[NCR_NIB_W-1:1]};
            NCR_OP_LOAD_ACC:      acc_reg <= i_operand;
            NCR_OP_SWAP_ACC_AUX:  acc_reg <= aux_reg;
            NCR_OP_AB_FROM_PAIR:  acc_reg <= pair_reg[NCR_NIB_W-1:0];
            NCR_OP_READ_STACK_PTR: acc_reg <= {1'b0, stack_index_reg};
            default:              acc_reg <= acc_reg;
         endcase
      end
   end

   // aux nibble: temporary store and high half of 8-bit moves
   // swap reads the old accumulator, both halves move at one edge
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         aux_reg <= NCR_AUX_RST;
      end else if (i_op == NCR_OP_INT_RETURN) begin
         aux_reg <= save_aux_reg;
      end else if (executes) begin
         case (i_op)
            NCR_OP_LOAD_AUX:     aux_reg <= i_operand;
            NCR_OP_SWAP_ACC_AUX: aux_reg <= acc_reg;
            NCR_OP_AB_FROM_PAIR: aux_reg <= pair_reg[NCR_PAIR_W-1:NCR_NIB_W];
            default:             aux_reg <= aux_reg;
         endcase
      end
   end

   // pair and page offset are not reset: software must load them first
   // a reset here would hide missing initialisation in software
   always_ff @(posedge i_clock) begin
      if (executes && i_op == NCR_OP_PAIR_FROM_AB) begin
         pair_reg <= {aux_reg, acc_reg};
      end
      if (executes && i_op == NCR_OP_LOAD_POFS) begin
         page_offset_reg <= i_operand[NCR_POFS_W-1:0];
      end
   end

   // carry flag
   // the other adds and the logic ops fall to the hold branch
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         carry_reg <= 1'b0;
      end else if (i_op == NCR_OP_INT_RETURN) begin
         carry_reg <= save_carry_reg;
      end else if (executes) begin
         case (i_op)
            NCR_OP_ADD_WITH_CARRY: carry_reg <= sum_next[NCR_NIB_W];
            NCR_OP_ROTATE_RIGHT:   carry_reg <= acc_reg[0];
            NCR_OP_SET_CARRY:      carry_reg <= 1'b1;
            NCR_OP_CLEAR_CARRY:    carry_reg <= 1'b0;
            default:               carry_reg <= carry_reg;
         endcase
      end
   end

   // skip flag: set by a true skip condition, consumed by the next slot
   // entry clears it so the handler starts clean; the saved copy returns
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         skip_reg <= 1'b0;
      end else if (i_op == NCR_OP_INT_RETURN) begin
         skip_reg <= save_skip_reg;
      end else if (i_op == NCR_OP_INT_ENTRY) begin
         skip_reg <= 1'b0;
      end else if (skip_reg) begin
         skip_reg <= 1'b0;
      end else begin
         case (i_op)
            NCR_OP_SET_SKIP:  skip_reg <= i_skip_cond;
            NCR_OP_CMP_MEM:   skip_reg <= (acc_reg == i_operand);
            NCR_OP_BIT_TEST:  skip_reg <= |(i_operand & bit_mask);
            NCR_OP_ADD_IMM:   skip_reg <= !sum_next[NCR_NIB_W];
            default:          skip_reg <= 1'b0;
         endcase
      end
   end

   // interrupt save stage, written only on interrupt entry
   // single stage: a nested interrupt would overwrite the first context
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         save_dptr_reg  <= '0;
         save_carry_reg <= 1'b0;
         save_skip_reg  <= 1'b0;
         save_acc_reg   <= NCR_ACC_RST;
         save_aux_reg   <= NCR_AUX_RST;
      end else if (i_op == NCR_OP_INT_ENTRY) begin
         save_dptr_reg  <= i_data_ptr;
         save_carry_reg <= carry_reg;
         save_skip_reg  <= skip_reg;
         save_acc_reg   <= acc_reg;
         save_aux_reg   <= aux_reg;
      end
   end

   // bit set and clear write back a modified memory nibble
   // the data nibble is registered every cycle, only the strobe qualifies it
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         mem_we_reg    <= 1'b0;
         mem_wdata_reg <= 4'h0;
      end else begin
         mem_we_reg    <= executes && (i_op == NCR_OP_BIT_SET || i_op == NCR_OP_BIT_CLR);
         mem_wdata_reg <= (i_op == NCR_OP_BIT_SET) ? (i_operand | bit_mask)
                                                   : (i_operand & ~bit_mask);
      end
   end

   // data pointer handed back to its owner on interrupt return
   // the owner must take the pointer in the cycle of the strobe
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         dptr_restore_valid_reg <= 1'b0;
         dptr_restore_reg       <= '0;
      end else begin
         dptr_restore_valid_reg <= (i_op == NCR_OP_INT_RETURN);
         dptr_restore_reg       <= save_dptr_reg;
      end
   end

   // return stack: no overflow guard, a ninth push overwrites entry 0
   // interrupts and lookups share the eight slots with calls
   always_ff @(posedge i_clock) begin
      if (is_push) begin
         return_stack_entry[push_index] <= pc_seq;
      end
   end

   // stack index tracks nesting, modulo eight both ways
   // a return with nothing pushed just wraps the index
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         stack_index_reg <= NCR_SIDX_RST;
      end else if (is_push) begin
         stack_index_reg <= push_index;
      end else if (executes && (i_op == NCR_OP_RETURN || i_op == NCR_OP_INT_RETURN)) begin
         stack_index_reg <= stack_index_reg - 3'h1;
      end
   end

   // program counter
   // a skipped slot still advances, so the slot after it runs next
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         pc_reg <= NCR_PC_RST;
      end else if (!executes) begin
         pc_reg <= pc_seq;
      end else begin
         case (i_op)
            NCR_OP_JUMP, NCR_OP_CALL, NCR_OP_INT_ENTRY: pc_reg <= i_target;
            NCR_OP_BRANCH_LONG_ACC, NCR_OP_CALL_LONG_ACC: pc_reg <= in_page_target;
            NCR_OP_TABLE_LOOKUP: pc_reg <= in_page_target;
            NCR_OP_RETURN, NCR_OP_INT_RETURN: pc_reg <= return_stack_entry[stack_index_reg];
            default: pc_reg <= pc_seq;
         endcase
      end
   end

   // every output comes straight from its flip-flop
   assign o_acc                    = acc_reg;
   assign o_aux                    = aux_reg;
   assign o_pair                   = pair_reg;
   assign o_carry_bit              = carry_reg;
   assign o_skip                   = skip_reg;
   assign o_stack_index            = stack_index_reg;
   assign o_pc                     = pc_reg;
   assign o_mem_wdata              = mem_wdata_reg;
   assign o_mem_we                 = mem_we_reg;
   assign o_data_ptr_restore       = dptr_restore_reg;
   assign o_data_ptr_restore_valid = dptr_restore_valid_reg;
endmodule
`default_nettype wire

//--- ncr_core_properties.sv
// concurrent checks for the nibble cpu datapath, seen from its ports only
// assumes one instruction clock and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module ncr_core_properties
   import ncr_pkg::*;
(
   input wire logic                          i_clock,
   input wire logic                          i_rst,
   input wire ncr_pkg::ncr_op_e              i_op,
   input wire logic [ncr_pkg::NCR_NIB_W-1:0] i_operand,
   input wire logic [ncr_pkg::NCR_NIB_W-1:0] o_acc,
   input wire logic [ncr_pkg::NCR_NIB_W-1:0] o_aux,
   input wire logic [ncr_pkg::NCR_PAIR_W-1:0] o_pair,
   input wire logic                          o_carry_bit,
   input wire logic                          o_skip,
   input wire logic [ncr_pkg::NCR_SIDX_W-1:0] o_stack_index,
   input wire logic [ncr_pkg::NCR_PC_W-1:0]  o_pc,
   input wire logic                          o_data_ptr_restore_valid
);
   // five-bit sum so the carry out of the nibble add is visible
   logic [4:0] awc_sum;
   logic       act;
   assign awc_sum = {1'b0, o_acc} + {1'b0, i_operand} + {4'h0, o_carry_bit};
   assign act = !o_skip;  // a skipped slot executes nothing

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   a_carry_set_op: assert property ((act && i_op == NCR_OP_SET_CARRY) |=> o_carry_bit)
      else $error("carry not set");
   a_carry_clear_op: assert property ((act && i_op == NCR_OP_CLEAR_CARRY) |=> !o_carry_bit)
      else $error("carry not cleared");
   a_carry_out_sum: assert property ((act && i_op == NCR_OP_ADD_WITH_CARRY) |=>
      (o_carry_bit == $past(awc_sum[4])) && (o_acc == $past(awc_sum[3:0])))
      else $error("add with carry wrong");
   a_carry_kept_add: assert property ((act && (i_op == NCR_OP_ADD_IMM
      || i_op == NCR_OP_ADD_MEMORY)) |=> $stable(o_carry_bit))
      else $error("carry changed by add");
   a_rotate_lsb_carry: assert property ((act && i_op == NCR_OP_ROTATE_RIGHT) |=>
      (o_carry_bit == $past(o_acc[0])) && (o_acc == {$past(o_carry_bit), $past(o_acc[3:1])}))
      else $error("rotate wrong");
   a_push_index_up: assert property ((i_op == NCR_OP_INT_ENTRY
      || (act && i_op == NCR_OP_CALL)) |=> o_stack_index == $past(o_stack_index) + 3'h1)
      else $error("index not advanced on push");
   a_pop_index_down: assert property ((i_op == NCR_OP_INT_RETURN
      || (act && i_op == NCR_OP_RETURN)) |=> o_stack_index == $past(o_stack_index) - 3'h1)
      else $error("index not lowered on return");
   a_pc_step_one: assert property (((o_skip && i_op != NCR_OP_INT_ENTRY
      && i_op != NCR_OP_INT_RETURN) || (act && i_op == NCR_OP_NOP))
      |=> o_pc == $past(o_pc) + 12'h001)
      else $error("pc did not step");
   a_pair_from_nibs: assert property ((act && i_op == NCR_OP_PAIR_FROM_AB) |=>
      o_pair == $past({o_aux, o_acc}))
      else $error("pair load wrong");
   a_index_to_acc: assert property ((act && i_op == NCR_OP_READ_STACK_PTR) |=>
      o_acc == {1'b0, $past(o_stack_index)})
      else $error("stack index not read into accumulator");
   a_restore_pulse_once: assert property (1'b1 |=>
      o_data_ptr_restore_valid == $past(i_op == NCR_OP_INT_RETURN))
      else $error("restore pulse wrong");
endmodule
bind ncr_core ncr_core_properties i_props (
   .i_clock(i_clock), .i_rst(i_rst), .i_op(i_op), .i_operand(i_operand), .o_acc(o_acc),
   .o_aux(o_aux), .o_pair(o_pair), .o_carry_bit(o_carry_bit), .o_skip(o_skip),
   .o_stack_index(o_stack_index), .o_pc(o_pc),
   .o_data_ptr_restore_valid(o_data_ptr_restore_valid));
`default_nettype wire

//--- testbench.sv
// self-checking bench for the nibble cpu datapath
// assumes decode is replaced by direct op driving, 10 ns after each rising edge
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import ncr_pkg::*;
   logic        i_clock = 1'b0;
   logic        i_rst   = 1'b1;
   ncr_op_e     i_op    = NCR_OP_NOP;
   logic [3:0]  i_operand = 4'h0;
   logic [1:0]  i_bit_sel = 2'h0;
   logic [11:0] i_target  = 12'h000;
   logic [7:0]  i_data_ptr = 8'h00;
   logic        i_skip_cond = 1'b0;
   logic [3:0]  o_acc, o_aux, o_mem_wdata;
   logic [7:0]  o_pair, o_data_ptr_restore;
   logic        o_carry_bit, o_skip, o_mem_we, o_data_ptr_restore_valid;
   logic [2:0]  o_stack_index;
   logic [11:0] o_pc;
   int          n_fail = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          k;

   ncr_core i_dut (
      .i_clock(i_clock), .i_rst(i_rst), .i_op(i_op), .i_operand(i_operand),
      .i_bit_sel(i_bit_sel), .i_target(i_target), .i_data_ptr(i_data_ptr),
      .i_skip_cond(i_skip_cond), .o_acc(o_acc), .o_aux(o_aux), .o_pair(o_pair),
      .o_carry_bit(o_carry_bit), .o_skip(o_skip), .o_stack_index(o_stack_index),
      .o_pc(o_pc), .o_mem_wdata(o_mem_wdata), .o_mem_we(o_mem_we),
      .o_data_ptr_restore(o_data_ptr_restore),
      .o_data_ptr_restore_valid(o_data_ptr_restore_valid));

   // 100 ns instruction clock
   always #50 i_clock = ~i_clock;

   // hang guard: the whole run needs well under a few hundred cycles
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one instruction slot; results are settled when the task returns
   task automatic op(input ncr_op_e o, input logic [3:0] d);
      i_op = o;
      i_operand = d;
      @(posedge i_clock);
      #10;
   endtask

   task automatic t_carry_alu();
      op(NCR_OP_SET_CARRY, 4'h0);     chk(o_carry_bit, 1);
      op(NCR_OP_CLEAR_CARRY, 4'h0);   chk(o_carry_bit, 0);
      op(NCR_OP_LOAD_ACC, 4'h9);
      op(NCR_OP_ADD_WITH_CARRY, 4'h8); chk({o_carry_bit, o_acc}, 5'h11);
      op(NCR_OP_ADD_WITH_CARRY, 4'h2); chk({o_carry_bit, o_acc}, 5'h04);
      op(NCR_OP_ADD_IMM, 4'hf);       chk({o_carry_bit, o_acc}, 5'h03);
      op(NCR_OP_SET_CARRY, 4'h0);
      op(NCR_OP_ADD_MEMORY, 4'h1);    chk({o_carry_bit, o_acc}, 5'h14);
      op(NCR_OP_ROTATE_RIGHT, 4'h0);  chk({o_carry_bit, o_acc}, 5'h0a);
      op(NCR_OP_ROTATE_RIGHT, 4'h0);  chk({o_carry_bit, o_acc}, 5'h05);
      op(NCR_OP_ROTATE_RIGHT, 4'h0);  chk({o_carry_bit, o_acc}, 5'h12);
      op(NCR_OP_LOAD_ACC, 4'hc);
      op(NCR_OP_AND_MEM, 4'h6);       chk(o_acc, 4'h4);
      op(NCR_OP_OR_MEM, 4'h1);        chk(o_acc, 4'h5);
      i_bit_sel = 2'h2;
      op(NCR_OP_BIT_SET, 4'h1);       chk({o_mem_we, o_mem_wdata}, 5'h15);
      op(NCR_OP_NOP, 4'h0);           chk(o_mem_we, 0);
      op(NCR_OP_BIT_CLR, 4'hf);       chk({o_mem_we, o_mem_wdata}, 5'h1b);
      op(NCR_OP_BIT_TEST, 4'h4);      chk(o_skip, 1);
      op(NCR_OP_NOP, 4'h0);           chk({o_skip, o_mem_we}, 2'h0);
   endtask

   task automatic t_pair();
      op(NCR_OP_LOAD_ACC, 4'h3);
      op(NCR_OP_LOAD_AUX, 4'hc);
      op(NCR_OP_PAIR_FROM_AB, 4'h0);  chk(o_pair, 8'hc3);
      op(NCR_OP_LOAD_ACC, 4'h0);
      op(NCR_OP_LOAD_AUX, 4'h0);
      op(NCR_OP_AB_FROM_PAIR, 4'h0);  chk({o_aux, o_acc}, 8'hc3);
      op(NCR_OP_SWAP_ACC_AUX, 4'h0);  chk({o_aux, o_acc}, 8'h3c);
   endtask

   // nine nested calls: the ninth wraps the index and overwrites entry zero
   task automatic t_stack();
      i_target = 12'h07f;
      op(NCR_OP_JUMP, 4'h0);
      op(NCR_OP_NOP, 4'h0);           chk(o_pc, 12'h080);
      for (k = 0; k < 9; k++) begin
         i_target = 12'h100 + 12'(k);
         op(NCR_OP_CALL, 4'h0);       chk({o_stack_index, o_pc}, {3'(k), i_target});
      end
      op(NCR_OP_READ_STACK_PTR, 4'h0); chk(o_acc, 4'h0);
      op(NCR_OP_RETURN, 4'h0);        chk({o_stack_index, o_pc}, 15'h7108);
      op(NCR_OP_RETURN, 4'h0);        chk({o_stack_index, o_pc}, 15'h6107);
   endtask

   task automatic t_page_offset();
      i_target = 12'h2c0;
      op(NCR_OP_JUMP, 4'h0);
      op(NCR_OP_LOAD_POFS, 4'h5);
      op(NCR_OP_LOAD_ACC, 4'ha);
      op(NCR_OP_BRANCH_LONG_ACC, 4'h0); chk(o_pc, 12'h2da);
      op(NCR_OP_TABLE_LOOKUP, 4'h0);  chk({o_stack_index, o_pc}, 15'h72da);
      op(NCR_OP_RETURN, 4'h0);        chk({o_stack_index, o_pc}, 15'h62db);
   endtask

   // interrupt taken while a skip is pending; context comes back on return
   task automatic t_interrupt();
      op(NCR_OP_LOAD_ACC, 4'h6);
      op(NCR_OP_LOAD_AUX, 4'h9);
      op(NCR_OP_SET_CARRY, 4'h0);
      i_skip_cond = 1'b1;
      op(NCR_OP_SET_SKIP, 4'h0);      chk(o_skip, 1);
      i_target = 12'h080;
      i_data_ptr = 8'h5b;
      op(NCR_OP_INT_ENTRY, 4'h0);     chk({o_skip, o_pc}, 13'h0080);
      op(NCR_OP_LOAD_ACC, 4'h0);
      op(NCR_OP_LOAD_AUX, 4'h0);
      op(NCR_OP_CLEAR_CARRY, 4'h0);
      i_target = 12'h100;
      op(NCR_OP_CALL, 4'h0);
      op(NCR_OP_RETURN, 4'h0);        chk(o_pc, 12'h084);
      op(NCR_OP_INT_RETURN, 4'h0);    chk({o_carry_bit, o_aux, o_acc}, 9'h196);
      chk({o_stack_index, o_pc}, 15'h62e0);
      chk({o_skip, o_data_ptr_restore_valid, o_data_ptr_restore}, 10'h35b);
      op(NCR_OP_LOAD_ACC, 4'hf);      chk({o_skip, o_acc}, 5'h06);
      op(NCR_OP_LOAD_ACC, 4'h3);
      op(NCR_OP_CMP_MEM, 4'h3);       chk(o_skip, 1);
      op(NCR_OP_LOAD_ACC, 4'h1);      chk(o_acc, 4'h3);
   endtask

   initial begin
      repeat (4) @(posedge i_clock);
      #10;
      i_rst = 1'b0;
      chk({o_stack_index, o_carry_bit, o_acc}, 8'he0);
      t_carry_alu();
      t_pair();
      t_stack();
      t_page_offset();
      t_interrupt();
      end_of_test();
   end
endmodule
`default_nettype wire
